// File: src/tpc_pkg.sv
// Constants for the transmit timestamp register bank
package tpc_pkg;
  localparam int AddrW = 16;
  // Register indices; byte address is four times the index
  localparam logic [11:0] IdxRevision = 12'ha00;
  localparam logic [11:0] IdxScratch = 12'ha01;
  localparam logic [11:0] IdxName0 = 12'ha02;
  localparam logic [11:0] IdxName1 = 12'ha03;
  localparam logic [11:0] IdxName2 = 12'ha04;
  localparam logic [11:0] IdxClkPeriod = 12'ha05;
  localparam logic [11:0] IdxRsvdFirst = 12'ha06;
  localparam logic [11:0] IdxRsvdLast = 12'ha0a;
  localparam logic [11:0] IdxAsym = 12'ha0b;
  localparam logic [11:0] IdxPmaLatency = 12'ha0c;
  // Field layout
  localparam int PeriodW = 20;
  localparam int PeriodNsLsb = 16;
  localparam int AsymW = 19;
  localparam int AsymEnBit = 18;
  localparam int AsymSubBit = 17;
  localparam int AsymMagW = 17;
  localparam int LatNsLsb = 16;
  // Reset values
  localparam logic [31:0] ScratchRst = 32'h0000_0000;
  localparam logic [19:0] PeriodRst = 20'h28f5c;
  localparam logic [18:0] AsymRst = 19'h0_0000;
  localparam logic [31:0] LatencyRst = 32'h0000_0000;
  // Arbitrary identification values
  localparam logic [31:0] RevisionCode = 32'h0001_0000;
  localparam logic [31:0] NameWord0 = 32'h5458_5453;
  localparam logic [31:0] NameWord1 = 32'h5245_4742;
  localparam logic [31:0] NameWord2 = 32'h414e_4b30;
endpackage

// File: src/tpc_csr.sv
// Transmit timestamp register bank with APB slave and delay adjust
`timescale 1ns/1ps

// Function
// - Index 0xa00 reads a fixed revision code and ignores writes.
// - A scratch word resets to zero, reads back what was written, steers nothing.
// - Three read-only words carry a twelve-character name, four per word, first word first.
// - A 20-bit clock period, 4 bits whole ns over 16 fraction bits, resets to 0x28f5c.
// - The asymmetry adjustment is applied to the final delay only when its enable is set.
// - The asymmetry sign bit set subtracts the magnitude, clear adds it.
// - The low 17 asymmetry bits are a magnitude in ns; the 19-bit word resets to zero.
// - A 32-bit serdes latency word, 16 bits ns over 16 fraction bits, resets to zero.
module tpc_csr #(
  parameter int DelayW = 32
) (
  input wire logic clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [tpc_pkg::AddrW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic delayValid,
  input wire logic [DelayW-1:0] delayIn,
  output logic delayOutValid,
  output logic [DelayW-1:0] delayOut,
  output logic [tpc_pkg::PeriodW-1:0] clkPeriod,
  output logic [31:0] pmaLatency
);
  import tpc_pkg::*;

  logic [31:0] scratch_q;
  logic [PeriodW-1:0] period_q;
  logic [AsymW-1:0] asym_q;
  logic [31:0] latency_q;
  logic [31:0] rdata_d;
  logic decodeHit;
  logic access;
  logic commit;
  logic [11:0] regIdx;
  logic takeReq;
  logic rspErr_d;
  logic [31:0] rspData_d;

  // Merge write data by byte strobe
  function automatic logic [31:0] merge(
    input logic [31:0] old,
    input logic [31:0] wdata,
    input logic [3:0] strb
  );
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = wdata[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True inside the gap between period and asymmetry words
  function automatic logic inRsvd(input logic [11:0] idx);
    return (idx >= IdxRsvdFirst) && (idx <= IdxRsvdLast);
  endfunction

  // Word aligned and inside the window of the bank
  function automatic logic addrInWindow(input logic [AddrW-1:0] addr);
    return (addr[1:0] == 2'h0) && (addr[AddrW-1:14] == '0);
  endfunction

  // Write strobe of one register index
  function automatic logic wrHit(
    input logic cmt,
    input logic [11:0] idx,
    input logic [11:0] want
  );
    return cmt && (idx == want);
  endfunction

  // Indices that answer without error, reserved gap included
  function automatic logic isMapped(input logic [11:0] idx);
    logic hit;
    hit = 1'b0;
    case (idx)
      IdxRevision, IdxScratch, IdxName0: hit = 1'b1;
      IdxName1, IdxName2, IdxClkPeriod: hit = 1'b1;
      IdxAsym, IdxPmaLatency: hit = 1'b1;
      default: hit = inRsvd(idx);
    endcase
    return hit;
  endfunction

  // Read value of one index; reserved and unknown give zero
  function automatic logic [31:0] readWord(
    input logic [11:0] idx,
    input logic [31:0] scratch,
    input logic [PeriodW-1:0] period,
    input logic [AsymW-1:0] asym,
    input logic [31:0] latency
  );
    logic [31:0] res;
    res = 32'h0000_0000;
    case (idx)
      IdxRevision: res = RevisionCode;
      IdxScratch: res = scratch;
      IdxName0: res = NameWord0;
      IdxName1: res = NameWord1;
      IdxName2: res = NameWord2;
      IdxClkPeriod: res = 32'(period);
      IdxAsym: res = 32'(asym);
      IdxPmaLatency: res = latency;
      default: res = 32'h0000_0000;
    endcase
    return res;
  endfunction

  // Adjust of the final delay; wraps modulo 2**DelayW, no saturation
  function automatic logic [DelayW-1:0] adjustDelay(
    input logic [DelayW-1:0] din,
    input logic [AsymW-1:0] asym
  );
    logic [DelayW-1:0] mag;
    logic [DelayW-1:0] res;
    mag = DelayW'(asym[AsymMagW-1:0]);
    res = din;
    if (asym[AsymEnBit]) begin
      if (asym[AsymSubBit]) begin
        res = din - mag;
      end else begin
        res = din + mag;
      end
    end
    return res;
  endfunction

  assign regIdx = paddr[13:2];
  assign access = psel && penable;
  assign takeReq = access && !pready;
  // Write takes effect only at the edge where pready is seen high
  assign commit = access && pready && pwrite && !pslverr;

  always_comb begin
    decodeHit = addrInWindow(paddr) && isMapped(regIdx);
    rdata_d = readWord(regIdx, scratch_q, period_q, asym_q, latency_q);
  end

  // Writes and refused accesses answer with zero data
  always_comb begin
    rspErr_d = !decodeHit;
    rspData_d = rdata_d;
    if (pwrite || !decodeHit) begin
      rspData_d = 32'h0000_0000;
    end
  end

  // One wait state: pready rises in the second access cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      pready <= 1'b0;
    end else if (ce) begin
      pready <= takeReq;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pslverr <= 1'b0;
    end else if (ce) begin
      pslverr <= takeReq && rspErr_d;
    end
  end

  // Read data holds until the next transfer is answered
  always_ff @(posedge clk) begin
    if (srst) begin
      prdata <= 32'h0000_0000;
    end else if (ce && takeReq) begin
      prdata <= rspData_d;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      scratch_q <= ScratchRst;
    end else if (ce && wrHit(commit, regIdx, IdxScratch)) begin
      scratch_q <= merge(scratch_q, pwdata, pstrb);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      period_q <= PeriodRst;
    end else if (ce && wrHit(commit, regIdx, IdxClkPeriod)) begin
      period_q <= PeriodW'(merge(32'(period_q), pwdata, pstrb));
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      asym_q <= AsymRst;
    end else if (ce && wrHit(commit, regIdx, IdxAsym)) begin
      asym_q <= AsymW'(merge(32'(asym_q), pwdata, pstrb));
    end
  end

  // Reset value is zero; software loads the recommended figure
  always_ff @(posedge clk) begin
    if (srst) begin
      latency_q <= LatencyRst;
    end else if (ce && wrHit(commit, regIdx, IdxPmaLatency)) begin
      latency_q <= merge(latency_q, pwdata, pstrb);
    end
  end

  // Output copies lag their registers by one cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      clkPeriod <= PeriodRst;
    end else if (ce) begin
      clkPeriod <= period_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pmaLatency <= LatencyRst;
    end else if (ce) begin
      pmaLatency <= latency_q;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      delayOutValid <= 1'b0;
    end else if (ce) begin
      delayOutValid <= delayValid;
    end
  end

  // Uses the asymmetry word as seen at the sampling edge
  always_ff @(posedge clk) begin
    if (srst) begin
      delayOut <= '0;
    end else if (ce) begin
      if (delayValid) begin
        delayOut <= adjustDelay(delayIn, asym_q);
      end
    end
  end
endmodule

// File: dv/tpc_csr_asserts.sv
// Checker on the register bank ports
`timescale 1ns/1ps
module tpc_csr_asserts (
  input logic clk,
  input logic srst,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [15:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic delayValid,
  input logic delayOutValid,
  input logic [31:0] delayOut,
  input logic [19:0] clkPeriod
);
  import tpc_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic rd;
  assign rd = pready && psel && !pwrite;
  rdy_pulse_a: assert property (ce && pready |=> !pready)
    else $error("pready too long");
  rdy_wait_a: assert property (ce && psel && penable && !pready |=> pready)
    else $error("no answer");
  rev_read_a: assert property (rd && paddr == 16'h2800 |->
    prdata == RevisionCode) else $error("bad revision");
  name_read_a: assert property (rd && paddr == 16'h2808 |->
    prdata == NameWord0) else $error("bad name");
  rsvd_zero_a: assert property (rd && paddr inside {[16'h2818:16'h2828]}
    && paddr[1:0] == 2'h0 |-> prdata == 32'h0 && !pslverr)
    else $error("bad gap");
  period_rst_a: assert property ($past(srst) |-> clkPeriod == PeriodRst)
    else $error("bad period reset");
  dly_valid_a: assert property (ce && delayValid |=> delayOutValid)
    else $error("no delay out");
  dly_hold_a: assert property (ce && !delayValid |=>
    $stable(delayOut) && !delayOutValid) else $error("delay moved");
  ce_freeze_a: assert property (!ce |=> $stable(pready) && $stable(prdata)
    && $stable(delayOut) && $stable(delayOutValid)) else $error("not frozen");
endmodule

// File: dv/tb.sv
// Self-checking bench for the register bank
`timescale 1ns/1ps
module tb;
  import tpc_pkg::*;
  logic clk = 0, srst = 1, ce = 1, psel = 0, penable = 0, pwrite = 0;
  logic delayValid = 0, pready, pslverr, delayOutValid;
  logic [15:0] paddr = 0;
  logic [31:0] pwdata = 0, delayIn = 0, prdata, delayOut, pmaLatency, d;
  logic [3:0] pstrb = 4'hf;
  logic [19:0] clkPeriod;
  logic [31:0] e[14], m[14], dq[$];
  logic [32:0] q[$];
  int n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 61;
  tpc_csr dut_u (
    .clk(clk),
    .srst(srst),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .delayValid(delayValid),
    .delayIn(delayIn),
    .delayOutValid(delayOutValid),
    .delayOut(delayOut),
    .clkPeriod(clkPeriod),
    .pmaLatency(pmaLatency)
  );
  initial forever #10 clk = ~clk;
  always @(posedge clk) if (++cyc > 3000) begin
    n_mismatch++;
    end_sim();
  end
  task end_sim();
    if (n_mismatch == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [32:0] g, x);
    samples_checked++;
    if (g !== x) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask
  // Index 13 is past the bank, so it must be refused
  task ap(input logic w, input int i, input logic [31:0] v,
    input logic [3:0] s);
    logic [31:0] bm;
    bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    q.push_back(i > 12 ? 33'h1_0000_0000 : w ? 33'h0 : {1'b0, e[i]});
    if (w) e[i] = e[i] & ~(m[i] & bm) | v & m[i] & bm;
    psel <= 1;
    pwrite <= w;
    paddr <= 16'h2800 + 16'(4 * i);
    pwdata <= v;
    pstrb <= s;
    @(posedge clk) penable <= 1;
    do @(posedge clk); while (!pready);
    psel <= 0;
    penable <= 0;
    @(posedge clk);
  endtask
  task init_model();
    e = '{RevisionCode, 0, NameWord0, NameWord1, NameWord2, PeriodRst,
      0, 0, 0, 0, 0, 0, 0, 0};
  endtask
  always @(posedge clk) begin
    if (pready && q.size() == 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t answer without request", $time);
    end else if (pready) begin
      chk(q.pop_front(), {pslverr, prdata});
    end
    // A frozen cycle keeps the same result standing
    if (ce && delayOutValid && dq.size() == 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t delay without input", $time);
    end else if (ce && delayOutValid) begin
      chk(dq.pop_front(), delayOut);
    end
  end
  initial begin
    init_model();
    m = '{0, '1, 0, 0, 0, 32'h000f_ffff, 0, 0, 0, 0, 0, 32'h0007_ffff, '1, 0};
    repeat (12) @(posedge clk);
    srst <= 0;
    @(posedge clk);
    for (int i = 0; i < 14; i++) ap(0, i, 0, 4'h0);
    for (int i = 0; i < 14; i++) begin
      ap(1, i, $random(seed), 4'($random(seed)));
    end
    @(posedge clk);
    chk({13'h0, clkPeriod}, {1'b0, e[5]});
    chk({1'b0, pmaLatency}, {1'b0, e[12]});
    for (int i = 0; i < 14; i++) ap(0, i, 0, 4'h0);
    ap(1, 12, 32'h0007_428f, 4'hf);
    ap(0, 12, 0, 4'h0);
    for (int k = 0; k < 4; k++) begin
      ap(1, 11, {13'h0, k[1:0], 17'($random(seed))}, 4'hf);
      d = $random(seed);
      dq.push_back(!e[11][18] ? d : e[11][17] ? d - e[11][16:0]
        : d + e[11][16:0]);
      delayValid <= 1;
      delayIn <= d;
      @(posedge clk) delayValid <= 0;
    end
    // A pulse offered while frozen must not be taken
    @(posedge clk);
    ce <= 0;
    delayValid <= 1;
    delayIn <= d;
    repeat (3) @(posedge clk);
    ce <= 1;
    delayValid <= 0;
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    init_model();
    @(posedge clk);
    chk({13'h0, clkPeriod}, {13'h0, PeriodRst});
    chk({1'b0, pmaLatency}, {1'b0, LatencyRst});
    ap(0, 1, 0, 4'h0);
    ap(0, 5, 0, 4'h0);
    ap(0, 11, 0, 4'h0);
    ap(0, 12, 0, 4'h0);
    repeat (3) @(posedge clk);
    if (q.size() != 0 || dq.size() != 0) begin
      n_mismatch++;
      $display("CHECK FAILED %0t answers missing", $time);
    end
    end_sim();
  end
endmodule
bind tpc_csr tpc_csr_asserts chk_u (
  .clk(clk),
  .srst(srst),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .delayValid(delayValid),
  .delayOutValid(delayOutValid),
  .delayOut(delayOut),
  .clkPeriod(clkPeriod)
);
